// ==== rtl/afe_front_end.sv ====
// four-port converter input front end with level detectors and gain scaling
`include "afe_defines.svh"
`default_nettype none

module afe_front_end #(
  parameter int RESAMP_DECIM = 1,
  parameter int DEC5_DECIM = 1,
  parameter int FIR_TAPS = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [`AFE_PORTS-1:0][`AFE_MANT_W-1:0] port_mantissa,
  input wire logic [`AFE_PORTS-1:0][`AFE_EXP_W-1:0] port_exponent,
  input wire logic [`AFE_PORTS-1:0] port_sample_qualifier,
  input wire logic [`AFE_ADDR_W-1:0] reg_addr,
  input wire logic [`AFE_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`AFE_DATA_W-1:0] reg_rdata,
  output logic [`AFE_PORTS-1:0] primary_level_flag,
  output logic [`AFE_PORTS-1:0] secondary_level_flag,
  output logic [`AFE_CHANS-1:0][`AFE_MANT_W-1:0] ch_sample,
  output logic [`AFE_CHANS-1:0] ch_strobe,
  output logic [`AFE_CHANS-1:0] ch_loud
);

  localparam logic [`AFE_DATA_W-1:0] LATENCY =
    `AFE_DATA_W'(RESAMP_DECIM * (DEC5_DECIM + `AFE_LAT_ADD) + FIR_TAPS + `AFE_LAT_BASE);

  afe_pkg::afe_state_t s_reg;
  afe_pkg::afe_state_t s_next;

  // magnitude of a signed mantissa, -8192 maps to 8192
  function automatic logic [`AFE_MANT_W-1:0] afe_mag(input logic [`AFE_MANT_W-1:0] v);
    afe_mag = v[`AFE_MANT_W-1] ? `AFE_MANT_W'(~v + `AFE_MANT_W'h1) : v;
  endfunction

  // next-state logic for the whole front end
  always_comb begin
    int p;
    int ph;
    logic q;
    logic qp;
    logic take;
    logic loud;
    logic dval;
    logic [`AFE_MANT_W-1:0] mag;
    logic [`AFE_MANT_W-1:0] data;
    logic [4:0] g;
    logic [4:0] sh;
    logic [`AFE_DETS-1:0] dly;
    afe_pkg::afe_qmode_t mode;
    p = 0;
    ph = 0;
    q = 1'b0;
    qp = 1'b0;
    take = 1'b0;
    loud = 1'b0;
    dval = 1'b0;
    mag = '0;
    data = '0;
    g = '0;
    sh = '0;
    dly = '0;
    mode = afe_pkg::AFE_Q_HIGH;
    s_next = s_reg;

    // pin inputs pass two flip-flops, captured on the sys_clk rising edge
    s_next.mant_s1 = port_mantissa;
    s_next.mant_s2 = s_reg.mant_s1;
    s_next.exp_s1 = port_exponent;
    s_next.exp_s2 = s_reg.exp_s1;
    s_next.q_s1 = port_sample_qualifier;
    s_next.q_s2 = s_reg.q_s1;
    s_next.q_prev = s_reg.q_s2;

    // eight detectors, two per port, on raw samples
    for (int d = 0; d < `AFE_DETS; d++) begin
      p = d / 2;
      ph = d % 2;
      mag = afe_mag(s_reg.mant_s2[p]);
      if (s_reg.ilv[p]) begin
        dval = (ph == 1) ? s_reg.q_s2[p] : !s_reg.q_s2[p];
      end else begin
        dval = (ph == 0);
      end
      if (dval && mag >= s_reg.upper[p]) begin
        s_next.flag[d] = 1'b1;
        s_next.run[d] = 1'b0;
        s_next.cnt[d] = s_reg.dwell[p];
      end else if (s_reg.flag[d]) begin
        if (dval && mag >= s_reg.lower[p]) begin
          s_next.run[d] = 1'b0;
          s_next.cnt[d] = s_reg.dwell[p];
        end else if (s_reg.run[d]) begin
          if (s_reg.cnt[d] == '0) begin
            s_next.flag[d] = 1'b0;
            s_next.run[d] = 1'b0;
          end else begin
            s_next.cnt[d] = s_reg.cnt[d] - `AFE_DWELL_W'h1;
          end
        end else if (dval) begin
          s_next.run[d] = 1'b1;
        end
      end
      if (!s_reg.ilv[p] && ph == 1) begin
        s_next.flag[d] = 1'b0;
        s_next.run[d] = 1'b0;
      end
    end

    // flag history for the gain alignment delay
    s_next.hist[0] = s_reg.flag;
    for (int k = 1; k < 7; k++) begin
      s_next.hist[k] = s_reg.hist[k-1];
    end
    dly = (s_reg.delay == 3'h0) ? s_reg.flag : s_reg.hist[3'(s_reg.delay - 3'h1)];

    // channel capture and scaling
    s_next.ch_strobe = '0;
    for (int c = 0; c < `AFE_CHANS; c++) begin
      p = ((c < 4) ? 0 : 2) + int'(s_reg.chsel[c]);
      q = s_reg.q_s2[p];
      qp = s_reg.q_prev[p];
      mode = afe_pkg::afe_qmode_t'(s_reg.modes[2*c +: 2]);
      case (mode)
        afe_pkg::AFE_Q_FALL: take = qp && !q;
        afe_pkg::AFE_Q_RISE: take = !qp && q;
        afe_pkg::AFE_Q_HIGH: take = q;
        afe_pkg::AFE_Q_BLANK: take = 1'b1;
        default: take = 1'b0;
      endcase
      data = (mode == afe_pkg::AFE_Q_BLANK && !q) ? '0 : s_reg.mant_s2[p];
      loud = (s_reg.ilv[p] && q) ? dly[2*p+1] : dly[2*p];
      g = loud ? s_reg.gain[`AFE_LOUD_MSB:`AFE_LOUD_LSB] :
                 s_reg.gain[`AFE_QUIET_MSB:`AFE_QUIET_LSB];
      sh = 5'(`AFE_EXP_TOP - {2'h0, s_reg.exp_s2[p]} + g);
      s_next.ch_strobe[c] = take;
      if (take) begin
        s_next.ch_sample[c] = `AFE_MANT_W'($signed(data) >>> sh);
        s_next.ch_loud[c] = loud;
      end
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `AFE_ADDR_MODE: s_next.modes = reg_wdata;
        `AFE_ADDR_ILV: s_next.ilv = reg_wdata[`AFE_PORTS-1:0];
        `AFE_ADDR_GAIN: s_next.gain = reg_wdata[9:0];
        `AFE_ADDR_CHSEL: s_next.chsel = reg_wdata[`AFE_CHANS-1:0];
        `AFE_ADDR_DELAY: s_next.delay = reg_wdata[2:0];
        default: begin
          case (reg_addr[7:2])
            `AFE_ADDR_UPPER: s_next.upper[reg_addr[1:0]] = reg_wdata[`AFE_MANT_W-1:0];
            `AFE_ADDR_LOWER: s_next.lower[reg_addr[1:0]] = reg_wdata[`AFE_MANT_W-1:0];
            `AFE_ADDR_DWELL: s_next.dwell[reg_addr[1:0]] = reg_wdata;
            default: s_next.cnt = s_next.cnt;
          endcase
        end
      endcase
    end

    // read data valid only in the cycle after the strobe
    s_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `AFE_ADDR_MODE: s_next.rdata = s_reg.modes;
        `AFE_ADDR_ILV: s_next.rdata = {12'h000, s_reg.ilv};
        `AFE_ADDR_GAIN: s_next.rdata = {6'h00, s_reg.gain};
        `AFE_ADDR_CHSEL: s_next.rdata = {8'h00, s_reg.chsel};
        `AFE_ADDR_DELAY: s_next.rdata = {13'h0000, s_reg.delay};
        `AFE_ADDR_STATUS: s_next.rdata = {8'h00, s_reg.sec, s_reg.prim};
        `AFE_ADDR_LATENCY: s_next.rdata = LATENCY;
        default: begin
          case (reg_addr[7:2])
            `AFE_ADDR_UPPER: s_next.rdata = {2'h0, s_reg.upper[reg_addr[1:0]]};
            `AFE_ADDR_LOWER: s_next.rdata = {2'h0, s_reg.lower[reg_addr[1:0]]};
            `AFE_ADDR_DWELL: s_next.rdata = s_reg.dwell[reg_addr[1:0]];
            default: s_next.rdata = '0;
          endcase
        end
      endcase
    end

    // level flag pins
    for (int x = 0; x < `AFE_PORTS; x++) begin
      s_next.prim[x] = s_next.flag[2*x];
      s_next.sec[x] = s_next.ilv[x] ? s_next.flag[2*x+1] : !s_next.flag[2*x];
    end
  end

  // state register, frozen while clk_en is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.modes <= `AFE_MODE_RST;
      s_reg.gain <= `AFE_GAIN_RST;
      s_reg.upper <= {`AFE_PORTS{`AFE_UPPER_RST}};
      s_reg.lower <= {`AFE_PORTS{`AFE_LOWER_RST}};
      s_reg.dwell <= {`AFE_PORTS{`AFE_DWELL_RST}};
      s_reg.sec <= '1;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = s_reg.rdata;
  assign primary_level_flag = s_reg.prim;
  assign secondary_level_flag = s_reg.sec;
  assign ch_sample = s_reg.ch_sample;
  assign ch_strobe = s_reg.ch_strobe;
  assign ch_loud = s_reg.ch_loud;

  // helper terms for detector 0 and channel 0
  logic [`AFE_MANT_W-1:0] a_mag0;
  logic a_val0;
  logic [1:0] a_mode0;
  assign a_mag0 = afe_mag(s_reg.mant_s2[0]);
  assign a_val0 = s_reg.ilv[0] ? !s_reg.q_s2[0] : 1'b1;
  assign a_mode0 = s_reg.modes[1:0];

  default clocking a_cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_secondary_inverse: assert property (
    !s_reg.ilv[0] |-> secondary_level_flag[0] == !primary_level_flag[0])
    else $error("secondary flag not inverse of primary");
  a_upper_sets_flag: assert property (
    clk_en && a_val0 && a_mag0 >= s_reg.upper[0] |=> s_reg.flag[0] && primary_level_flag[0])
    else $error("upper threshold did not raise flag");
  a_dwell_holds: assert property (
    clk_en && s_reg.flag[0] && s_reg.run[0] && s_reg.cnt[0] != '0 |=> s_reg.flag[0])
    else $error("flag dropped before dwell expired");
  a_dwell_expires: assert property (
    clk_en && s_reg.flag[0] && s_reg.run[0] && s_reg.cnt[0] == '0 &&
    !(a_val0 && a_mag0 >= s_reg.lower[0]) |=> !s_reg.flag[0])
    else $error("flag kept after dwell expired");
  a_dwell_restart: assert property (
    clk_en && s_reg.flag[0] && a_val0 && a_mag0 >= s_reg.lower[0]
    |=> !s_reg.run[0] && s_reg.cnt[0] == $past(s_reg.dwell[0]))
    else $error("dwell counter not reset above lower threshold");
  a_blank_zero: assert property (
    clk_en && a_mode0 == afe_pkg::AFE_Q_BLANK && !s_reg.chsel[0] && !s_reg.q_s2[0]
    |=> ch_strobe[0] && ch_sample[0] == '0)
    else $error("blank mode passed a nonzero sample");
  a_high_gates: assert property (
    clk_en && a_mode0 == afe_pkg::AFE_Q_HIGH && !s_reg.chsel[0] && !s_reg.q_s2[0]
    |=> !ch_strobe[0])
    else $error("level-high mode took a sample while low");
  a_fall_capture: assert property (
    clk_en && a_mode0 == afe_pkg::AFE_Q_FALL && !s_reg.chsel[0] &&
    s_reg.q_prev[0] && !s_reg.q_s2[0] |=> ch_strobe[0])
    else $error("falling transition not captured");
  a_rise_once: assert property (
    clk_en && a_mode0 == afe_pkg::AFE_Q_RISE && !s_reg.chsel[0] &&
    !(!s_reg.q_prev[0] && s_reg.q_s2[0]) |=> !ch_strobe[0])
    else $error("rising mode captured without a new transition");
  a_gain_read: assert property (
    clk_en && reg_rd && reg_addr == `AFE_ADDR_GAIN |=> reg_rdata == {6'h00, $past(s_reg.gain)})
    else $error("gain register read back wrong");

  // capture rules of channel 0 on port A
  a_rise_capture: assert property (
    clk_en && a_mode0 == afe_pkg::AFE_Q_RISE && !s_reg.chsel[0] &&
    !s_reg.q_prev[0] && s_reg.q_s2[0] |=> ch_strobe[0])
    else $error("rising transition not captured");

  a_fall_once: assert property (
    clk_en && a_mode0 == afe_pkg::AFE_Q_FALL && !s_reg.chsel[0] &&
    !(s_reg.q_prev[0] && !s_reg.q_s2[0]) |=> !ch_strobe[0])
    else $error("falling mode captured without a new transition");

  a_high_takes: assert property (
    clk_en && a_mode0 == afe_pkg::AFE_Q_HIGH && !s_reg.chsel[0] && s_reg.q_s2[0]
    |=> ch_strobe[0])
    else $error("level-high mode missed a sample while high");

  // port selection follows the channel select bits
  a_port_b_select: assert property (
    clk_en && a_mode0 == afe_pkg::AFE_Q_HIGH && s_reg.chsel[0] && !s_reg.q_s2[1]
    |=> !ch_strobe[0])
    else $error("channel 0 ignored the port B qualifier");

  a_port_c_select: assert property (
    clk_en && s_reg.modes[9:8] == 2'h3 && !s_reg.chsel[4] && !s_reg.q_s2[2]
    |=> !ch_strobe[4])
    else $error("channel 4 ignored the port C qualifier");

  // gain selection delay on channel 0
  a_delay_zero: assert property (
    clk_en && s_reg.delay == 3'h0 && !s_reg.ilv[0] && a_mode0 == afe_pkg::AFE_Q_BLANK &&
    !s_reg.chsel[0] |=> ch_loud[0] == $past(s_reg.flag[0]))
    else $error("gain selection not from the current flag");

  a_delay_two: assert property (
    clk_en && s_reg.delay == 3'h2 && !s_reg.ilv[0] && a_mode0 == afe_pkg::AFE_Q_BLANK &&
    !s_reg.chsel[0] |=> ch_loud[0] == $past(s_reg.hist[1][0]))
    else $error("gain selection not delayed by two clocks");

  // scaling of channel 0 with a zero scale field
  a_quiet_scale: assert property (
    clk_en && a_mode0 == afe_pkg::AFE_Q_BLANK && !s_reg.chsel[0] && !s_reg.ilv[0] &&
    s_reg.delay == 3'h0 && !s_reg.flag[0] && s_reg.q_s2[0] && s_reg.exp_s2[0] == 3'h7 &&
    s_reg.gain[9:5] == 5'h00 |=> ch_sample[0] == $past(s_reg.mant_s2[0]))
    else $error("quiet scale changed an unscaled sample");

  a_loud_scale: assert property (
    clk_en && a_mode0 == afe_pkg::AFE_Q_BLANK && !s_reg.chsel[0] && !s_reg.ilv[0] &&
    s_reg.delay == 3'h0 && s_reg.flag[0] && s_reg.q_s2[0] && s_reg.exp_s2[0] == 3'h7 &&
    s_reg.gain[4:0] == 5'h00 |=> ch_loud[0] && ch_sample[0] == $past(s_reg.mant_s2[0]))
    else $error("loud scale not used while flag active");

  a_exp_shift: assert property (
    clk_en && a_mode0 == afe_pkg::AFE_Q_BLANK && !s_reg.chsel[0] && !s_reg.ilv[0] &&
    s_reg.delay == 3'h0 && !s_reg.flag[0] && s_reg.q_s2[0] && s_reg.exp_s2[0] == 3'h6 &&
    s_reg.gain[9:5] == 5'h00
    |=> ch_sample[0] == `AFE_MANT_W'($signed($past(s_reg.mant_s2[0])) >>> 1))
    else $error("exponent did not shift the sample by one");

  // interleaved and plain detector pairing on port 0
  a_det1_cleared: assert property (
    clk_en && !s_reg.ilv[0] |=> !s_reg.flag[1])
    else $error("second detector active without interleave");

  a_ilv_primary: assert property (
    clk_en && s_reg.ilv[0] && s_reg.q_s2[0] && !s_reg.flag[0] |=> !s_reg.flag[0])
    else $error("primary detector used a qualifier-high sample");

  a_ilv_secondary: assert property (
    clk_en && !reg_wr && s_reg.ilv[0] && s_reg.q_s2[0] && a_mag0 >= s_reg.upper[0]
    |=> s_reg.flag[1] && secondary_level_flag[0])
    else $error("secondary detector missed a loud qualifier-high sample");

  // register read port
  a_read_idle: assert property (
    clk_en && !reg_rd |=> reg_rdata == '0)
    else $error("read data present without a read strobe");

  a_mode_read: assert property (
    clk_en && reg_rd && reg_addr == `AFE_ADDR_MODE |=> reg_rdata == $past(s_reg.modes))
    else $error("mode register read back wrong");

  a_latency_read: assert property (
    clk_en && reg_rd && reg_addr == `AFE_ADDR_LATENCY |=> reg_rdata == LATENCY)
    else $error("latency register read back wrong");

endmodule
`default_nettype wire

// ==== rtl/afe_defines.svh ====
// register offsets, field positions, reset values and fixed figures of the input front end
`ifndef AFE_DEFINES_SVH
`define AFE_DEFINES_SVH

`define AFE_PORTS 4
`define AFE_CHANS 8
`define AFE_DETS 8
`define AFE_MANT_W 14
`define AFE_EXP_W 3
`define AFE_DWELL_W 16
`define AFE_DATA_W 16
`define AFE_ADDR_W 8

`define AFE_ADDR_MODE 8'h90
`define AFE_ADDR_ILV 8'h91
`define AFE_ADDR_GAIN 8'h92
`define AFE_ADDR_CHSEL 8'h93
`define AFE_ADDR_UPPER 6'h25
`define AFE_ADDR_LOWER 6'h26
`define AFE_ADDR_DWELL 6'h27
`define AFE_ADDR_DELAY 8'hA0
`define AFE_ADDR_STATUS 8'hA1
`define AFE_ADDR_LATENCY 8'hA2

`define AFE_QUIET_MSB 9
`define AFE_QUIET_LSB 5
`define AFE_LOUD_MSB 4
`define AFE_LOUD_LSB 0

`define AFE_MODE_RST 16'hFFFF
`define AFE_UPPER_RST 14'h3FFF
`define AFE_LOWER_RST 14'h0000
`define AFE_DWELL_RST 16'h0000
`define AFE_GAIN_RST 10'h000
`define AFE_EXP_TOP 5'h07
`define AFE_LAT_ADD 7
`define AFE_LAT_BASE 26

`endif

// ==== rtl/afe_pkg.sv ====
// types of the input front end
`include "afe_defines.svh"
`default_nettype none
package afe_pkg;
  // sample qualifier modes, Gray order
  typedef enum logic [1:0] {
    AFE_Q_FALL = 2'h0,
    AFE_Q_RISE = 2'h1,
    AFE_Q_HIGH = 2'h3,
    AFE_Q_BLANK = 2'h2
  } afe_qmode_t;

  typedef struct packed {
    logic [`AFE_PORTS-1:0][`AFE_MANT_W-1:0] mant_s1;
    logic [`AFE_PORTS-1:0][`AFE_MANT_W-1:0] mant_s2;
    logic [`AFE_PORTS-1:0][`AFE_EXP_W-1:0] exp_s1;
    logic [`AFE_PORTS-1:0][`AFE_EXP_W-1:0] exp_s2;
    logic [`AFE_PORTS-1:0] q_s1;
    logic [`AFE_PORTS-1:0] q_s2;
    logic [`AFE_PORTS-1:0] q_prev;
    logic [`AFE_DETS-1:0] flag;
    logic [`AFE_DETS-1:0] run;
    logic [`AFE_DETS-1:0][`AFE_DWELL_W-1:0] cnt;
    logic [6:0][`AFE_DETS-1:0] hist;
    logic [15:0] modes;
    logic [`AFE_PORTS-1:0] ilv;
    logic [`AFE_CHANS-1:0] chsel;
    logic [9:0] gain;
    logic [`AFE_PORTS-1:0][`AFE_MANT_W-1:0] upper;
    logic [`AFE_PORTS-1:0][`AFE_MANT_W-1:0] lower;
    logic [`AFE_PORTS-1:0][`AFE_DWELL_W-1:0] dwell;
    logic [2:0] delay;
    logic [`AFE_CHANS-1:0][`AFE_MANT_W-1:0] ch_sample;
    logic [`AFE_CHANS-1:0] ch_strobe;
    logic [`AFE_CHANS-1:0] ch_loud;
    logic [`AFE_PORTS-1:0] prim;
    logic [`AFE_PORTS-1:0] sec;
    logic [`AFE_DATA_W-1:0] rdata;
  } afe_state_t;
endpackage
`default_nettype wire

// ==== testbench/afe_adc_model.sv ====
// converter model that drives the four input ports of the front end
`include "afe_defines.svh"
`default_nettype none
module afe_adc_model (
  input wire logic sys_clk,
  input wire logic [`AFE_PORTS-1:0][`AFE_MANT_W-1:0] lo_val,
  input wire logic [`AFE_PORTS-1:0][`AFE_MANT_W-1:0] hi_val,
  input wire logic [`AFE_PORTS-1:0][`AFE_EXP_W-1:0] exp_val,
  input wire logic [`AFE_PORTS-1:0] phase_run,
  input wire logic [`AFE_PORTS-1:0] phase_hold,
  output logic [`AFE_PORTS-1:0][`AFE_MANT_W-1:0] port_mantissa,
  output logic [`AFE_PORTS-1:0][`AFE_EXP_W-1:0] port_exponent,
  output logic [`AFE_PORTS-1:0] port_sample_qualifier
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_reg = 2'h0;
  logic phase = 1'b0;
  // phase select flips every four clocks, as a multiplexed converter does
  always @(posedge sys_clk) begin
    div_reg <= div_reg + 2'h1;
    if (div_reg == 2'h3) begin
      phase <= ~phase;
    end
  end
  // each port shows the word of its current phase and its exponent
  always_comb begin
    for (int p = 0; p < `AFE_PORTS; p++) begin
      port_sample_qualifier[p] = phase_run[p] ? phase : phase_hold[p];
      port_mantissa[p] = port_sample_qualifier[p] ? hi_val[p] : lo_val[p];
      port_exponent[p] = exp_val[p];
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench of the input front end
`include "afe_defines.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [`AFE_ADDR_W-1:0] reg_addr = 8'h00;
  logic [`AFE_DATA_W-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [`AFE_DATA_W-1:0] reg_rdata;
  logic [`AFE_PORTS-1:0] prim;
  logic [`AFE_PORTS-1:0] sec;
  logic [`AFE_CHANS-1:0][`AFE_MANT_W-1:0] ch_sample;
  logic [`AFE_CHANS-1:0] ch_strobe;
  logic [`AFE_CHANS-1:0] ch_loud;
  logic [`AFE_PORTS-1:0][`AFE_MANT_W-1:0] lo_val = '0;
  logic [`AFE_PORTS-1:0][`AFE_MANT_W-1:0] hi_val = '0;
  logic [`AFE_PORTS-1:0][`AFE_EXP_W-1:0] exp_val = {4{3'h7}};
  logic [`AFE_PORTS-1:0] phase_run = 4'h0;
  logic [`AFE_PORTS-1:0] phase_hold = 4'hF;
  logic [`AFE_PORTS-1:0][`AFE_MANT_W-1:0] mant;
  logic [`AFE_PORTS-1:0][`AFE_EXP_W-1:0] expo;
  logic [`AFE_PORTS-1:0] qual;
  int err_count = 0;
  int checks_done = 0;
  int cnt [4];
  int chs [4] = '{0, 3, 4, 7};
  int want_cnt [4] = '{16, 4, 4, 32};

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  afe_adc_model i_adc (.sys_clk(sys_clk), .lo_val(lo_val), .hi_val(hi_val),
    .exp_val(exp_val), .phase_run(phase_run), .phase_hold(phase_hold),
    .port_mantissa(mant), .port_exponent(expo), .port_sample_qualifier(qual));

  afe_front_end #(.RESAMP_DECIM(2), .DEC5_DECIM(3), .FIR_TAPS(4)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .port_mantissa(mant),
    .port_exponent(expo), .port_sample_qualifier(qual), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .primary_level_flag(prim), .secondary_level_flag(sec), .ch_sample(ch_sample),
    .ch_strobe(ch_strobe), .ch_loud(ch_loud));

  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
    checks_done++;
    if (got !== want) begin
      err_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // one-cycle write strobe beside address and data
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [15:0] want);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, want, "register read");
  endtask

  task automatic set_val(input int p, input logic [13:0] v);
    @(posedge sys_clk);
    lo_val[p] <= v;
    hi_val[p] <= v;
  endtask

  // bounded wait for the port 0 primary flag to reach a level
  task automatic wait_flag(input logic lvl, input int lim);
    int n;
    n = 0;
    while (prim[0] !== lvl) begin
      if (n == lim) begin
        err_count++;
        $display("wrong value at %0t: level flag did not change in time", $time);
        print_verdict();
      end
      cycles(1);
      n++;
    end
    checks_done++;
  endtask

  task automatic count_strobes(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      cycles(1);
      for (int c = 0; c < 4; c++) cnt[c] += ch_strobe[c];
    end
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    reg_read(8'h92, 16'h0000);
    reg_write(8'h92, 16'hFFFF);
    reg_read(8'h92, 16'h03FF);
    reg_read(8'hA2, 16'h0032);
    reg_read(8'h00, 16'h0000);
    // quiet scale 0, loud scale 2; ch3 from port B, ch7 from port D
    reg_write(8'h92, 16'h0002);
    reg_write(8'h93, 16'h0088);
    for (int p = 0; p < 4; p++) set_val(p, 14'h0100 + 14'(p));
    cycles(6);
    for (int i = 0; i < 4; i++) check({2'h0, ch_sample[chs[i]]}, 16'h0100 + 16'(i), "select");
    // exponent 6 gives one arithmetic right shift
    set_val(0, 14'h3F00);
    exp_val[0] <= 3'h6;
    cycles(6);
    check({2'h0, ch_sample[0]}, 16'h3F80, "exponent scaling");
    // reset modes are level-high, so switch every channel to blank-when-low
    reg_write(8'h90, 16'hAAAA);
    exp_val[0] <= 3'h7;
    phase_hold[0] <= 1'b0;
    cycles(6);
    check({2'h0, ch_sample[0]}, 16'h0000, "blank sample");
    check({15'h0, ch_strobe[0]}, 16'h0001, "blank strobe");
    // ch0 level-high, ch1 falling, ch2 rising on the toggling port A qualifier, ch3 blank on port B
    reg_write(8'h90, 16'hAA93);
    phase_run[0] <= 1'b1;
    cycles(8);
    count_strobes(32);
    for (int c = 0; c < 4; c++) check(16'(cnt[c]), 16'(want_cnt[c]), "strobes");
    // detector on port 0: upper 0x1000, lower 0x0800, dwell 5
    phase_run[0] <= 1'b0;
    phase_hold[0] <= 1'b1;
    reg_write(8'h90, 16'hFFFF);
    reg_write(8'h94, 16'h1000);
    reg_write(8'h98, 16'h0800);
    reg_write(8'h9C, 16'h0005);
    set_val(0, 14'h2800);
    wait_flag(1'b1, 10);
    check({15'h0, sec[0]}, 16'h0000, "secondary flag");
    cycles(6);
    check({15'h0, ch_loud[0]}, 16'h0001, "loud select");
    check({2'h0, ch_sample[0]}, 16'h3A00, "loud scaling");
    set_val(0, 14'h0400);
    cycles(4);
    check({15'h0, prim[0]}, 16'h0001, "dwell hold");
    wait_flag(1'b0, 12);
    cycles(4);
    check({15'h0, ch_loud[0]}, 16'h0000, "quiet select");
    // a return above the lower threshold restarts the dwell count
    set_val(0, 14'h1800);
    wait_flag(1'b1, 10);
    set_val(0, 14'h0400);
    cycles(3);
    set_val(0, 14'h0900);
    cycles(15);
    check({15'h0, prim[0]}, 16'h0001, "dwell restart");
    set_val(0, 14'h0400);
    wait_flag(1'b0, 14);
    // interleaved port 0: loud data only in the qualifier-high phase
    reg_write(8'h91, 16'h0001);
    lo_val[0] <= 14'h0000;
    hi_val[0] <= 14'h1800;
    phase_run[0] <= 1'b1;
    cycles(24);
    check({14'h0, sec[0], prim[0]}, 16'h0002, "interleaved flags");
    reg_read(8'hA1, 16'h00F0);
    print_verdict();
  end
endmodule
`default_nettype wire
